// ---- rtl/c6cal_pkg.sv ----
// Package of register map, field layout and encodings for the channel 6 register set
package c6cal_pkg;

  // Printed offsets are register indices; byte address is four times the index
  localparam int unsigned    C6CAL_IDX_W        = 6;
  localparam logic [5:0]     C6CAL_IDX_CFG      = 6'h27;
  localparam logic [5:0]     C6CAL_IDX_OFS_HI   = 6'h28;
  localparam logic [5:0]     C6CAL_IDX_OFS_LO   = 6'h29;
  localparam logic [5:0]     C6CAL_IDX_GAIN_HI  = 6'h2A;
  localparam logic [5:0]     C6CAL_IDX_GAIN_LO  = 6'h2B;

  // Reset values
  localparam logic [15:0]    C6CAL_RST_CFG      = 16'h0000;
  localparam logic [15:0]    C6CAL_RST_OFS_HI   = 16'h0000;
  localparam logic [15:0]    C6CAL_RST_OFS_LO   = 16'h0000;
  localparam logic [15:0]    C6CAL_RST_GAIN_HI  = 16'h8000;
  localparam logic [15:0]    C6CAL_RST_GAIN_LO  = 16'h0000;

  // Writable bits of each register; reserved bits are zero here
  localparam logic [15:0]    C6CAL_MASK_CFG     = 16'hFFC7;
  localparam logic [15:0]    C6CAL_MASK_FULL    = 16'hFFFF;
  localparam logic [15:0]    C6CAL_MASK_LO      = 16'hFF00;

  // Field positions in the configuration register and in the low calibration words
  localparam int unsigned    C6CAL_PHASE_MSB    = 15;
  localparam int unsigned    C6CAL_PHASE_LSB    = 6;
  localparam int unsigned    C6CAL_DCOFF_BIT    = 2;
  localparam int unsigned    C6CAL_SEL_MSB      = 1;
  localparam int unsigned    C6CAL_SEL_LSB      = 0;
  localparam int unsigned    C6CAL_LOBYTE_MSB   = 15;
  localparam int unsigned    C6CAL_LOBYTE_LSB   = 8;

  // Input selector encodings
  typedef enum logic [1:0] {
    C6CAL_SEL_PINS    = 2'h0,
    C6CAL_SEL_SHORT   = 2'h1,
    C6CAL_SEL_TST_POS = 2'h2,
    C6CAL_SEL_TST_NEG = 2'h3
  } c6cal_sel_t;

endpackage : c6cal_pkg

// ---- rtl/c6cal_regs.sv ----
// Channel 6 configuration and calibration registers behind an Avalon-MM slave
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module c6cal_regs
  import c6cal_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Avalon-MM slave, word address is the register index
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic      [1:0]           avs_response,
  output logic                      avs_waitrequest,
  // Global DC filter enable from the device-wide setting
  input  wire logic                 global_dc_filter_setting,
  // Channel controls
  output logic signed [9:0]         chan_phase_delay,
  output logic                      chan_dc_filter_off,
  output logic                      chan_dc_filter_active,
  output c6cal_pkg::c6cal_sel_t     chan_input_select,
  output logic                      sel_own_pins,
  output logic                      sel_shorted,
  output logic                      sel_test_pos,
  output logic                      sel_test_neg,
  // Calibration values
  output logic signed [23:0]        offset_corr,
  output logic        [23:0]        gain_corr
);
  import c6cal_pkg::*;

  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  logic [15:0] cfg_q;
  logic [15:0] ofs_hi_q;
  logic [15:0] ofs_lo_q;
  logic [15:0] gain_hi_q;
  logic [15:0] gain_lo_q;
  logic [15:0] cfg_d;
  logic [15:0] ofs_hi_d;
  logic [15:0] ofs_lo_d;
  logic [15:0] gain_hi_d;
  logic [15:0] gain_lo_d;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [1:0]  resp_q;

  // Request decode
  logic        req;
  logic        hit_cfg;
  logic        hit_ohi;
  logic        hit_olo;
  logic        hit_ghi;
  logic        hit_glo;
  logic        hit_any;
  logic        wr_en;
  logic        rd_en;

  // Per-register write strobes
  logic        wr_cfg;
  logic        wr_ohi;
  logic        wr_olo;
  logic        wr_ghi;
  logic        wr_glo;

  // Readback views with reserved bits forced to zero
  logic [15:0] rd_cfg;
  logic [15:0] rd_ohi;
  logic [15:0] rd_olo;
  logic [15:0] rd_ghi;
  logic [15:0] rd_glo;
  logic [15:0] rd_mux;

  // Bus answer next values
  logic        ack_d;
  logic [31:0] rdata_d;
  logic [1:0]  resp_d;

  // Raw field slices
  logic [9:0]  phase_raw;
  logic [1:0]  sel_raw;
  logic [7:0]  ofs_lo_byte;
  logic [7:0]  gain_lo_byte;

  // Merge write data under byte enables and the writable mask
  function automatic logic [15:0] c6cal_merge(input logic [15:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be,
                                              input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
    return (old_v & ~lanes) | (wd[15:0] & lanes);
  endfunction : c6cal_merge

  // Register index match, shared by write and read decode
  function automatic logic c6cal_hit(input logic [5:0] addr,
                                     input logic [5:0] idx);
    return addr == idx;
  endfunction : c6cal_hit

  // A request is taken only in its first cycle, before the answer
  assign req     = (avs_read | avs_write) & ~ack_q;
  assign hit_cfg = c6cal_hit(avs_address, C6CAL_IDX_CFG);
  assign hit_ohi = c6cal_hit(avs_address, C6CAL_IDX_OFS_HI);
  assign hit_olo = c6cal_hit(avs_address, C6CAL_IDX_OFS_LO);
  assign hit_ghi = c6cal_hit(avs_address, C6CAL_IDX_GAIN_HI);
  assign hit_glo = c6cal_hit(avs_address, C6CAL_IDX_GAIN_LO);
  assign hit_any = hit_cfg | hit_ohi | hit_olo | hit_ghi | hit_glo;
  assign wr_en   = req & avs_write;
  assign rd_en   = req & avs_read;

  // Writes land at the edge that takes the request
  assign wr_cfg  = wr_en & hit_cfg;
  assign wr_ohi  = wr_en & hit_ohi;
  assign wr_olo  = wr_en & hit_olo;
  assign wr_ghi  = wr_en & hit_ghi;
  assign wr_glo  = wr_en & hit_glo;

  // Writes merged per register; reserved bits held at zero by the masks
  assign cfg_d     = wr_cfg ?
                     c6cal_merge(cfg_q, avs_writedata, avs_byteenable, C6CAL_MASK_CFG) :
                     cfg_q;
  assign ofs_hi_d  = wr_ohi ?
                     c6cal_merge(ofs_hi_q, avs_writedata, avs_byteenable, C6CAL_MASK_FULL) :
                     ofs_hi_q;
  assign ofs_lo_d  = wr_olo ?
                     c6cal_merge(ofs_lo_q, avs_writedata, avs_byteenable, C6CAL_MASK_LO) :
                     ofs_lo_q;
  assign gain_hi_d = wr_ghi ?
                     c6cal_merge(gain_hi_q, avs_writedata, avs_byteenable, C6CAL_MASK_FULL) :
                     gain_hi_q;
  assign gain_lo_d = wr_glo ?
                     c6cal_merge(gain_lo_q, avs_writedata, avs_byteenable, C6CAL_MASK_LO) :
                     gain_lo_q;

  // Reserved bits also masked on the read path
  assign rd_cfg = cfg_q & C6CAL_MASK_CFG;
  assign rd_ohi = ofs_hi_q & C6CAL_MASK_FULL;
  assign rd_olo = ofs_lo_q & C6CAL_MASK_LO;
  assign rd_ghi = gain_hi_q & C6CAL_MASK_FULL;
  assign rd_glo = gain_lo_q & C6CAL_MASK_LO;

  // Read mux, upper 16 bits read zero
  assign rd_mux = hit_cfg ? rd_cfg :
                  hit_ohi ? rd_ohi :
                  hit_olo ? rd_olo :
                  hit_ghi ? rd_ghi :
                  hit_glo ? rd_glo : 16'h0000;

  // One wait cycle: request seen, answer on the next edge
  assign ack_d   = req;
  assign rdata_d = rd_en ? {16'h0000, rd_mux} : rdata_q;
  assign resp_d  = req ? (hit_any ? RESP_OK : RESP_DECERR) : resp_q;

  // Configuration register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= C6CAL_RST_CFG;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Offset correction, high word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ofs_hi_q <= C6CAL_RST_OFS_HI;
    end else begin
      ofs_hi_q <= ofs_hi_d;
    end
  end

  // Offset correction, low word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ofs_lo_q <= C6CAL_RST_OFS_LO;
    end else begin
      ofs_lo_q <= ofs_lo_d;
    end
  end

  // Gain correction, high word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_hi_q <= C6CAL_RST_GAIN_HI;
    end else begin
      gain_hi_q <= gain_hi_d;
    end
  end

  // Gain correction, low word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_lo_q <= C6CAL_RST_GAIN_LO;
    end else begin
      gain_lo_q <= gain_lo_d;
    end
  end

  // Answer flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // Read data stands until the next read is taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Response stands until the next request is taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_q <= RESP_OK;
    end else begin
      resp_q <= resp_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign avs_response    = resp_q;

  // Raw fields
  assign phase_raw    = cfg_q[C6CAL_PHASE_MSB:C6CAL_PHASE_LSB];
  assign sel_raw      = cfg_q[C6CAL_SEL_MSB:C6CAL_SEL_LSB];
  assign ofs_lo_byte  = ofs_lo_q[C6CAL_LOBYTE_MSB:C6CAL_LOBYTE_LSB];
  assign gain_lo_byte = gain_lo_q[C6CAL_LOBYTE_MSB:C6CAL_LOBYTE_LSB];

  // Field decode
  assign chan_phase_delay      = signed'(phase_raw);
  assign chan_dc_filter_off    = cfg_q[C6CAL_DCOFF_BIT];
  assign chan_dc_filter_active = global_dc_filter_setting & ~chan_dc_filter_off;
  assign chan_input_select     = c6cal_sel_t'(sel_raw);
  assign sel_own_pins          = chan_input_select == C6CAL_SEL_PINS;
  assign sel_shorted           = chan_input_select == C6CAL_SEL_SHORT;
  assign sel_test_pos          = chan_input_select == C6CAL_SEL_TST_POS;
  assign sel_test_neg          = chan_input_select == C6CAL_SEL_TST_NEG;

  // Offset is signed: high word carries bits 23:8
  assign offset_corr = signed'({ofs_hi_q, ofs_lo_byte});

  // Gain is unsigned: 800000h is unity
  assign gain_corr   = {gain_hi_q, gain_lo_byte};

endmodule : c6cal_regs

// ---- tb/c6cal_props.sv ----
// Concurrent checks on the channel 6 register set ports
`timescale 1ns/1ps
module c6cal_props
  import c6cal_pkg::*;
(
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  // Bus
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  // Channel controls
  input wire logic                  global_dc_filter_setting,
  input wire logic                  chan_dc_filter_off,
  input wire logic                  chan_dc_filter_active,
  input wire c6cal_pkg::c6cal_sel_t chan_input_select,
  input wire logic                  sel_own_pins,
  input wire logic                  sel_shorted,
  input wire logic                  sel_test_pos,
  input wire logic                  sel_test_neg,
  input wire logic signed [23:0]    offset_corr,
  input wire logic [23:0]           gain_corr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    (avs_read | avs_write) && avs_waitrequest;
  endsequence
  a_ack_next: assert property (s_taken |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_idle_ready: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  a_dc_follow: assert property (chan_dc_filter_active == (global_dc_filter_setting & !chan_dc_filter_off))
    else $error("dc filter state wrong");
  a_sel_pins: assert property (sel_own_pins == (chan_input_select == 2'h0) && sel_shorted == (chan_input_select == 2'h1))
    else $error("pin or short select wrong");
  a_sel_test: assert property (sel_test_pos == (chan_input_select == 2'h2) && sel_test_neg == (chan_input_select == 2'h3))
    else $error("test signal select wrong");
  a_hi_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_cal_hold: assert property (!avs_write |=> $stable(offset_corr) && $stable(gain_corr))
    else $error("calibration changed without write");
  a_rst_vals: assert property ($rose(rst_n) |-> gain_corr == 24'h800000 && offset_corr == 24'h000000)
    else $error("calibration reset values wrong");
endmodule : c6cal_props
bind c6cal_regs c6cal_props i_c6cal_props (.*);

// ---- tb/c6cal_regs_tb.sv ----
// Self-checking bench for the channel 6 register set
`timescale 1ns/1ps
module c6cal_regs_tb;
  import c6cal_pkg::*;
  logic core_clk, rst_n, avs_read, avs_write, global_dc_filter_setting, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response;
  logic chan_dc_filter_off, chan_dc_filter_active, sel_own_pins, sel_shorted;
  logic sel_test_pos, sel_test_neg;
  logic signed [9:0] chan_phase_delay;
  logic signed [23:0] offset_corr;
  logic [23:0] gain_corr;
  c6cal_sel_t chan_input_select;
  int fails, comparisons;
  c6cal_regs i_c6cal_regs (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic stop_test;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One bus cycle, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= !w;
    // Look just after each edge, once waitrequest has settled
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) fails++;
    q = avs_readdata;
    @(posedge core_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc
  task automatic rdchk(input logic [5:0] a, input logic [15:0] e, input logic [1:0] r);
    acc(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
    chk({30'h0, avs_response}, {30'h0, r});
  endtask : rdchk
  task automatic t_reset;
    rdchk(C6CAL_IDX_CFG, 16'h0000, 2'h0);
    rdchk(C6CAL_IDX_OFS_HI, 16'h0000, 2'h0);
    rdchk(C6CAL_IDX_OFS_LO, 16'h0000, 2'h0);
    rdchk(C6CAL_IDX_GAIN_HI, 16'h8000, 2'h0);
    rdchk(C6CAL_IDX_GAIN_LO, 16'h0000, 2'h0);
    chk(gain_corr, 32'h00800000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_cfg;
    logic [1:0] k;
    for (int s = 0; s < 4; s++) begin
      k = s[1:0];
      global_dc_filter_setting <= k[0];
      acc(1'b1, C6CAL_IDX_CFG, {8'h80, 5'b01111, k[1], k});
      rdchk(C6CAL_IDX_CFG, {8'h80, 5'b01000, k[1], k}, 2'h0);
      chk(chan_phase_delay, 32'hFFFFFE01);
      chk(chan_dc_filter_active, {31'h0, k[0] & !k[1]});
      chk({sel_test_neg, sel_test_pos, sel_shorted, sel_own_pins}, 32'h1 << s);
    end
    $display("config test done");
  endtask : t_cfg
  task automatic t_cal;
    acc(1'b1, C6CAL_IDX_OFS_HI, 16'h8001);
    acc(1'b1, C6CAL_IDX_OFS_LO, 16'hA5FF);
    chk(offset_corr, 32'hFF8001A5);
    rdchk(C6CAL_IDX_OFS_LO, 16'hA500, 2'h0);
    acc(1'b1, C6CAL_IDX_GAIN_HI, 16'hFFFF);
    acc(1'b1, C6CAL_IDX_GAIN_LO, 16'hFFFF);
    chk(gain_corr, 32'h00FFFFFF);
    rdchk(C6CAL_IDX_GAIN_LO, 16'hFF00, 2'h0);
    $display("calibration test done");
  endtask : t_cal
  task automatic t_bad;
    acc(1'b1, 6'h2C, 16'h1234);
    rdchk(6'h2C, 16'h0000, 2'h3);
    rdchk(6'h26, 16'h0000, 2'h3);
    avs_byteenable <= 4'h1;
    acc(1'b1, C6CAL_IDX_OFS_HI, 16'h1234);
    avs_byteenable <= 4'hF;
    rdchk(C6CAL_IDX_OFS_HI, 16'h8034, 2'h0);
    chk(gain_corr, 32'h00FFFFFF);
    $display("refusal test done");
  endtask : t_bad
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, global_dc_filter_setting} = 3'h0;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_cfg();
    t_cal();
    t_bad();
    stop_test();
  end
  initial begin
    #50000;
    fails++;
    stop_test();
  end
endmodule : c6cal_regs_tb
